// ==== design/pesl_regs.svh ====
// register offsets, reset values, field positions and timing for the event status latches
// assumes an 8-bit register address space on a plain strobe port
`ifndef PESL_REGS_SVH
`define PESL_REGS_SVH

// documented event registers
`define PESL_OFF_STARTUP      8'h65
`define PESL_OFF_MISC         8'h66
`define PESL_OFF_MODERATE     8'h67
`define PESL_OFF_SEVERE       8'h68
// mask registers, same layout, one per event register
`define PESL_OFF_MASK_BASE    8'h70
// live status, regulator request and recovery limit
`define PESL_OFF_LIVE         8'h74
`define PESL_OFF_REGCTL       8'h75
`define PESL_OFF_RECOV_LIM    8'h76

`define PESL_RST_FLAGS        8'h00
`define PESL_RST_MASK         8'h00
`define PESL_RST_REGREQ       4'h0
`define PESL_RST_RECOV_LIM    8'hff

// write-one-to-clear bits per register; the rest is plain storage
`define PESL_W1C_STARTUP      8'h32
`define PESL_W1C_MISC         8'h0b
`define PESL_W1C_MODERATE     8'hdf
`define PESL_W1C_SEVERE       8'h07

// startup register bits
`define PESL_B_SOFT_REBOOT    5
`define PESL_B_FIRST_POWER    4
`define PESL_B_ENABLE_PIN     1
// misc register bits
`define PESL_B_TWARN          3
`define PESL_B_EXT_CLK_LOSS   1
`define PESL_B_SELFTEST_DONE  0
// moderate error register bits
`define PESL_B_RSTOUT_RB      7
`define PESL_B_IRQ_RB         6
`define PESL_B_PM_BUS_ERR     4
`define PESL_B_RECOV_LIMIT    3
`define PESL_B_REG_CRC        2
`define PESL_B_SELFTEST_FAIL  1
`define PESL_B_TSD_ORD        0

// gap between regulator turn-offs in the sequenced shutdown
`define PESL_SEQ_STEP_NS      1000
`define PESL_CLK_MHZ          40
`define PESL_SEQ_STEP_CYC     ((`PESL_SEQ_STEP_NS * `PESL_CLK_MHZ) / 1000)

`endif

// ==== design/pesl_pkg.sv ====
// types shared by the event status latch block
// assumes the constants header is included where offsets are needed
package pesl_pkg;

  // one register access from the host side
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pesl_bus_s;

  // one-cycle event pulses and the external clock valid level from same-clock monitors
  typedef struct packed {
    logic       soft_reboot;
    logic       first_power;
    logic       ext_clk_valid;
    logic       selftest_done;
    logic       logic_selftest_fail;
    logic       analog_selftest_fail;
    logic       pm_bus_error;
    logic       reg_crc_error;
    logic [2:0] severe;
  } pesl_evt_s;

  typedef enum logic [0:0] {
    PESL_RUN      = 1'b0,
    PESL_SEQ_OFF  = 1'b1
  } pesl_state_e;

endpackage

// ==== design/pesl_top.sv ====
// latched, write-one-to-clear event status registers with masked interrupt
// assumes one 40 MHz clock; pins pass two flops, monitor pulses are same-clock
//
// The address-and-strobe port was decided locally.
`include "pesl_regs.svh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pesl_top
  import pesl_pkg::*;
#(
  parameter int RCNT_W   = 8,
  parameter int STEP_CYC = `PESL_SEQ_STEP_CYC,
  parameter int NREG     = 4
)
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // register port
  input  wire pesl_bus_s         bus,
  output logic [7:0]             rdata_q,
  // event sources on this clock
  input  wire pesl_evt_s         evt,
  input  wire logic              thermal_warning_live,
  input  wire logic              ordered_thermal_shutdown_live,
  input  wire logic [RCNT_W-1:0] recovery_counter,
  input  wire logic              reset_out_level,
  // pins, asynchronous
  input  wire logic              enable_pin,
  input  wire logic              reset_output_pin,
  input  wire logic              irq_output_pin,
  // outputs
  output logic                   irq_q,
  output logic [3:0]             reg_en_q,
  output logic                   clk_int_sel_q
);

  // elaboration checks
  if (RCNT_W < 1 || RCNT_W > 8)
  begin : g_chk_w
    $error("recovery counter width must be 1 to 8");
  end
  if (STEP_CYC < 1 || STEP_CYC > 65536)
  begin : g_chk_step
    $error("shutdown step must be 1 to 65536 cycles for the 16-bit counter");
  end
  if (NREG != 4)
  begin : g_chk_nreg
    $error("block serves exactly four event registers");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0]        pin_s1_q;
  logic [2:0]        pin_s2_q;
  logic              en_prev_q;
  logic [1:0]        rst_drv_dly_q;
  logic [1:0]        irq_drv_dly_q;

  // two flops per pin; only the second is read by logic
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end
    else
    begin
      pin_s1_q <= {irq_output_pin, reset_output_pin, enable_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  // driven levels delayed to line up with the synchronised sense
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_prev_q     <= 1'b0;
      rst_drv_dly_q <= 2'h0;
      irq_drv_dly_q <= 2'h0;
    end
    else
    begin
      en_prev_q     <= pin_s2_q[0];
      rst_drv_dly_q <= {rst_drv_dly_q[0], reset_out_level};
      irq_drv_dly_q <= {irq_drv_dly_q[0], irq_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // monitor edges

  logic              twarn_prev_q;
  logic              tsd_prev_q;
  logic              clkv_prev_q;
  logic [RCNT_W-1:0] rcnt_prev_q;
  logic [7:0]        recov_lim_q;

  // previous values for edge and change detection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      twarn_prev_q <= 1'b0;
      tsd_prev_q   <= 1'b0;
      clkv_prev_q  <= 1'b1;
      rcnt_prev_q  <= '0;
    end
    else
    begin
      twarn_prev_q <= thermal_warning_live;
      tsd_prev_q   <= ordered_thermal_shutdown_live;
      clkv_prev_q  <= evt.ext_clk_valid;
      rcnt_prev_q  <= recovery_counter;
    end
  end

  logic twarn_rise;
  logic tsd_rise;
  logic clk_lost;
  logic rcnt_hit;
  logic en_rise;
  logic rst_rb_err;
  logic irq_rb_err;

  // edges only, so a clear while the cause persists sticks
  assign twarn_rise = thermal_warning_live & ~twarn_prev_q;
  assign tsd_rise   = ordered_thermal_shutdown_live & ~tsd_prev_q;
  assign clk_lost   = ~evt.ext_clk_valid & clkv_prev_q;
  assign en_rise    = pin_s2_q[0] & ~en_prev_q;
  // counter must move onto the limit, not just sit there
  assign rcnt_hit   = (recovery_counter == recov_lim_q[RCNT_W-1:0])
                    && (recovery_counter != rcnt_prev_q);
  // pin sense against what was driven two cycles ago
  assign rst_rb_err = pin_s2_q[1] ^ rst_drv_dly_q[1];
  assign irq_rb_err = pin_s2_q[2] ^ irq_drv_dly_q[1];

  ////////////////////////////////////////////////////////////////////////////////
  // event vectors per register

  logic [7:0] ev [NREG];
  logic [7:0] w1c [NREG];

  always_comb
  begin
    ev[0] = 8'h00;
    ev[1] = 8'h00;
    ev[2] = 8'h00;
    ev[3] = 8'h00;
    ev[0][`PESL_B_SOFT_REBOOT]   = evt.soft_reboot;
    ev[0][`PESL_B_FIRST_POWER]   = evt.first_power;
    ev[0][`PESL_B_ENABLE_PIN]    = en_rise;
    ev[1][`PESL_B_TWARN]         = twarn_rise;
    ev[1][`PESL_B_EXT_CLK_LOSS]  = clk_lost;
    ev[1][`PESL_B_SELFTEST_DONE] = evt.selftest_done;
    ev[2][`PESL_B_RSTOUT_RB]     = rst_rb_err;
    ev[2][`PESL_B_IRQ_RB]        = irq_rb_err;
    ev[2][`PESL_B_PM_BUS_ERR]    = evt.pm_bus_error;
    ev[2][`PESL_B_RECOV_LIMIT]   = rcnt_hit;
    ev[2][`PESL_B_REG_CRC]       = evt.reg_crc_error;
    ev[2][`PESL_B_SELFTEST_FAIL] = evt.logic_selftest_fail
                                 | evt.analog_selftest_fail;
    ev[2][`PESL_B_TSD_ORD]       = tsd_rise;
    ev[3][2:0]                   = evt.severe;
  end

  assign w1c[0] = `PESL_W1C_STARTUP;
  assign w1c[1] = `PESL_W1C_MISC;
  assign w1c[2] = `PESL_W1C_MODERATE;
  assign w1c[3] = `PESL_W1C_SEVERE;

  ////////////////////////////////////////////////////////////////////////////////
  // flag and mask registers

  logic [7:0] flag_q [NREG];
  logic [7:0] mask_q [NREG];
  logic [7:0] pend   [NREG];
  logic [7:0] off_flag [NREG];

  assign off_flag[0] = `PESL_OFF_STARTUP;
  assign off_flag[1] = `PESL_OFF_MISC;
  assign off_flag[2] = `PESL_OFF_MODERATE;
  assign off_flag[3] = `PESL_OFF_SEVERE;

  for (genvar i = 0; i < NREG; i++)
  begin : g_reg
    logic wr_flag;
    logic wr_mask;
    logic [7:0] flag_d;

    assign wr_flag = bus.wr && (bus.addr == off_flag[i]);
    assign wr_mask = bus.wr && (bus.addr == (`PESL_OFF_MASK_BASE + 8'(i)));

    // ones clear w1c bits, reserved bits store; events win over clear
    always_comb
    begin
      flag_d = flag_q[i];
      if (wr_flag)
      begin
        flag_d = (flag_q[i] & w1c[i] & ~bus.wdata)
               | (bus.wdata & ~w1c[i]);
      end
      flag_d = flag_d | (ev[i] & w1c[i]);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        flag_q[i] <= `PESL_RST_FLAGS;
      end
      else
      begin
        flag_q[i] <= flag_d;
      end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        mask_q[i] <= `PESL_RST_MASK;
      end
      else if (wr_mask)
      begin
        mask_q[i] <= bus.wdata;
      end
    end

    // only latched bits can interrupt
    assign pend[i] = flag_q[i] & mask_q[i] & w1c[i];
  end

  // level interrupt while any unmasked flag stands
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |{pend[0], pend[1], pend[2], pend[3]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  logic [3:0] reg_req_q;
  logic       wr_regctl;
  logic       wr_lim;

  assign wr_regctl = bus.wr && (bus.addr == `PESL_OFF_REGCTL);
  assign wr_lim    = bus.wr && (bus.addr == `PESL_OFF_RECOV_LIM);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_req_q   <= `PESL_RST_REGREQ;
      recov_lim_q <= `PESL_RST_RECOV_LIM;
    end
    else
    begin
      if (wr_regctl)
      begin
        reg_req_q <= bus.wdata[3:0];
      end
      if (wr_lim)
      begin
        recov_lim_q <= bus.wdata;
      end
    end
  end

  // internal clock held while the external one is invalid
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_int_sel_q <= 1'b0;
    end
    else
    begin
      clk_int_sel_q <= ~evt.ext_clk_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // regulator enables and sequenced shutdown

  pesl_state_e state_q;
  logic [15:0] step_cnt_q;
  logic        tsd_flag;
  logic        step_done;

  assign tsd_flag  = flag_q[2][`PESL_B_TSD_ORD];
  assign step_done = (step_cnt_q == 16'(STEP_CYC - 1));

  // highest regulator goes first; one step per interval
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_q    <= PESL_RUN;
      step_cnt_q <= 16'h0000;
      reg_en_q   <= 4'h0;
    end
    else
    begin
      unique case (state_q)
        PESL_RUN:
        begin
          step_cnt_q <= 16'h0000;
          if (tsd_rise)
          begin
            state_q <= PESL_SEQ_OFF;
          end
          else if (tsd_flag)
          begin
            reg_en_q <= 4'h0;
          end
          else
          begin
            reg_en_q <= reg_req_q;
          end
        end
        PESL_SEQ_OFF:
        begin
          if (reg_en_q == 4'h0)
          begin
            state_q <= PESL_RUN;
          end
          else if (step_done)
          begin
            step_cnt_q <= 16'h0000;
            if (reg_en_q[3])
            begin
              reg_en_q[3] <= 1'b0;
            end
            else if (reg_en_q[2])
            begin
              reg_en_q[2] <= 1'b0;
            end
            else if (reg_en_q[1])
            begin
              reg_en_q[1] <= 1'b0;
            end
            else
            begin
              reg_en_q[0] <= 1'b0;
            end
          end
          else
          begin
            step_cnt_q <= step_cnt_q + 16'h0001;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe

  logic [7:0] rd_d;

  always_comb
  begin
    rd_d = 8'h00;
    unique case (bus.addr)
      `PESL_OFF_STARTUP:        rd_d = flag_q[0];
      `PESL_OFF_MISC:           rd_d = flag_q[1];
      `PESL_OFF_MODERATE:       rd_d = flag_q[2];
      `PESL_OFF_SEVERE:         rd_d = flag_q[3];
      `PESL_OFF_MASK_BASE:      rd_d = mask_q[0];
      `PESL_OFF_MASK_BASE + 8'h01: rd_d = mask_q[1];
      `PESL_OFF_MASK_BASE + 8'h02: rd_d = mask_q[2];
      `PESL_OFF_MASK_BASE + 8'h03: rd_d = mask_q[3];
      `PESL_OFF_LIVE:           rd_d = {4'h0, state_q == PESL_SEQ_OFF, clk_int_sel_q,
                                        ordered_thermal_shutdown_live, thermal_warning_live};
      `PESL_OFF_REGCTL:         rd_d = {reg_en_q, reg_req_q};
      `PESL_OFF_RECOV_LIM:      rd_d = recov_lim_q;
      default:                  rd_d = 8'h00;
    endcase
  end

  // unmapped reads and idle cycles return zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_q <= 8'h00;
    end
    else
    begin
      rdata_q <= bus.rd ? rd_d : 8'h00;
    end
  end

endmodule

`default_nettype wire

// ==== dv/pesl_asserts.sv ====
// port checker for the event status latch block
// assumes the pesl_top ports; bound from the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pesl_asserts
  import pesl_pkg::*;
#(
  parameter int STEP_CYC = 40
)
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // register port
  input wire pesl_bus_s  bus,
  input wire logic [7:0] rdata_q,
  // event side
  input wire pesl_evt_s  evt,
  input wire logic       ordered_thermal_shutdown_live,
  // outputs
  input wire logic       irq_q,
  input wire logic [3:0] reg_en_q,
  input wire logic       clk_int_sel_q
);
  // four steps plus slack for edge detect and state entry
  localparam int SHUT_MAX = 4 * STEP_CYC + 12;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  // read data stands only in the slot after a read
  property p_rdata_idle;
    !$past(bus.rd) |-> rdata_q == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
  // clock loss switches to the internal source next cycle
  property p_clk_sel;
    $fell(evt.ext_clk_valid) |=> clk_int_sel_q;
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("internal clock not selected");
  property p_clk_back;
    clk_int_sel_q |-> !$past(evt.ext_clk_valid);
  endproperty
  a_clk_back: assert property (p_clk_back) else $error("internal clock without loss");
  // sequenced shutdown completes in bounded time
  property p_shut_off;
    $rose(ordered_thermal_shutdown_live) |-> ##[1:SHUT_MAX] reg_en_q == 4'h0;
  endproperty
  a_shut_off: assert property (p_shut_off) else $error("regulators not shut down");
  // lowest regulator goes last when no request write explains it
  property p_shut_order;
    $fell(reg_en_q[0]) && !$past(bus.wr) && !$past(bus.wr, 2) |-> reg_en_q[3:1] == 3'h0;
  endproperty
  a_shut_order: assert property (p_shut_order) else $error("shutdown order broken");
  // an enable never appears on its own, only after software acts
  property p_en_gain;
    (reg_en_q & ~$past(reg_en_q)) != 4'h0 |-> $past(bus.wr) || $past(bus.wr, 2) || $past(bus.wr, 3);
  endproperty
  a_en_gain: assert property (p_en_gain) else $error("regulator enabled without write");
  // interrupt drops only two cycles after a write
  property p_irq_fall;
    $fell(irq_q) |-> $past(bus.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
  property p_irq_hold;
    irq_q && !bus.wr && !$past(bus.wr) |=> irq_q;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt not held");
endmodule

bind pesl_top pesl_asserts #(.STEP_CYC(STEP_CYC)) i_pesl_asserts (
  .clk(clk), .rst_b(rst_b), .bus(bus), .rdata_q(rdata_q), .evt(evt),
  .ordered_thermal_shutdown_live(ordered_thermal_shutdown_live),
  .irq_q(irq_q), .reg_en_q(reg_en_q), .clk_int_sel_q(clk_int_sel_q)
);
`default_nettype wire

// ==== dv/pesl_host.sv ====
// host software model: register reads and write-one acknowledges
// assumes it is called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module pesl_host
  import pesl_pkg::*;
(
  // clock
  input wire logic       clk,
  // register port, master side
  output var pesl_bus_s  bus,
  input wire logic [7:0] rdata_q
);
  initial bus = '0;

  // one write cycle, then an idle cycle so strobes never double up
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  // read data only exists in the slot after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    @(negedge clk);
    d = rdata_q;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== dv/pmic_event_status_latches_test.sv ====
// self-checking bench for the event status latch block
// assumes pesl_top, the host model and a short shutdown step
`timescale 1ns/1ps
`default_nettype none
module pmic_event_status_latches_test;
  import pesl_pkg::*;
  localparam int STEP = 2;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  pesl_bus_s  bus;
  logic [7:0] rdata_q;
  pesl_evt_s  evt;
  logic       thermal_warning_live, ordered_thermal_shutdown_live, reset_out_level;
  logic       enable_pin, brk_rst, brk_irq, irq_q, clk_int_sel_q;
  logic [7:0] recovery_counter;
  logic [3:0] reg_en_q;
  wire logic  reset_output_pin = reset_out_level ^ brk_rst;
  wire logic  irq_output_pin = irq_q ^ brk_irq;
  int         fail_count = 0;
  int         comparisons = 0;
  // event table: register and expected flag per source
  logic [7:0] ev_addr [14] = '{8'h65, 8'h65, 8'h65, 8'h66, 8'h66, 8'h66, 8'h67,
                               8'h67, 8'h67, 8'h67, 8'h67, 8'h67, 8'h67, 8'h68};
  logic [7:0] ev_bit [14] = '{8'h20, 8'h10, 8'h02, 8'h08, 8'h02, 8'h01, 8'h80,
                              8'h40, 8'h10, 8'h08, 8'h04, 8'h02, 8'h02, 8'h07};

  always #12.5 clk = ~clk;

  pesl_top #(.STEP_CYC(STEP)) i_pesl_top (
    .clk(clk), .rst_b(rst_b), .bus(bus), .rdata_q(rdata_q), .evt(evt),
    .thermal_warning_live(thermal_warning_live), .ordered_thermal_shutdown_live(ordered_thermal_shutdown_live),
    .recovery_counter(recovery_counter), .reset_out_level(reset_out_level), .enable_pin(enable_pin),
    .reset_output_pin(reset_output_pin), .irq_output_pin(irq_output_pin), .irq_q(irq_q),
    .reg_en_q(reg_en_q), .clk_int_sel_q(clk_int_sel_q)
  );
  pesl_host i_pesl_host (.clk(clk), .bus(bus), .rdata_q(rdata_q));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_pesl_host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask

  // sampled mid-cycle so the launching edge has landed
  task automatic irqchk(input logic e);
    @(negedge clk);
    chk("irq_q", {7'h00, e}, {7'h00, irq_q});
    @(posedge clk);
  endtask

  // drive one event source active or idle
  task automatic fire(input int i, input logic on);
    case (i)
      0: evt.soft_reboot <= on;
      1: evt.first_power <= on;
      2: enable_pin <= on;
      3: thermal_warning_live <= on;
      4: evt.ext_clk_valid <= !on;
      5: evt.selftest_done <= on;
      6: brk_rst <= on;
      7: brk_irq <= on;
      8: evt.pm_bus_error <= on;
      9: recovery_counter <= on ? 8'h05 : 8'h00;
      10: evt.reg_crc_error <= on;
      11: evt.logic_selftest_fail <= on;
      12: evt.analog_selftest_fail <= on;
      default: evt.severe <= on ? 3'h7 : 3'h0;
    endcase
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] a [7] = '{8'h65, 8'h66, 8'h67, 8'h68, 8'h70, 8'h73, 8'h50};
    for (int i = 0; i < 7; i++)
      rdchk(a[i], 8'h00);
    rdchk(8'h76, 8'hff);
  endtask

  // reserved bits are plain storage, an unmapped address keeps nothing
  task automatic t_reserved;
    logic [7:0] p [4] = '{8'hcd, 8'hf4, 8'h20, 8'hf8};
    for (int i = 0; i < 4; i++)
    begin
      i_pesl_host.wr(8'(8'h65 + i), p[i]);
      rdchk(8'(8'h65 + i), p[i]);
      i_pesl_host.wr(8'(8'h65 + i), 8'h00);
      rdchk(8'(8'h65 + i), 8'h00);
    end
    i_pesl_host.wr(8'h50, 8'hff);
    rdchk(8'h50, 8'h00);
  endtask

  task automatic t_events;
    i_pesl_host.wr(8'h76, 8'h05);
    for (int i = 0; i < 14; i++)
    begin
      fire(i, 1'b1);
      repeat (5) @(posedge clk);
      if (i == 3)
        rdchk(8'h74, 8'h01);
      if (i == 4)
      begin
        chk("clk_int_sel_q", 8'h01, {7'h00, clk_int_sel_q});
        rdchk(8'h74, 8'h04);
      end
      fire(i, 1'b0);
      repeat (5) @(posedge clk);
      rdchk(ev_addr[i], ev_bit[i]);
      i_pesl_host.wr(ev_addr[i], 8'h00);
      rdchk(ev_addr[i], ev_bit[i]);
      i_pesl_host.wr(ev_addr[i], ev_bit[i]);
      rdchk(ev_addr[i], 8'h00);
    end
    // a pin that follows its driven level is no readback error
    reset_out_level <= 1'b1;
    repeat (5) @(posedge clk);
    reset_out_level <= 1'b0;
    repeat (5) @(posedge clk);
    rdchk(8'h67, 8'h00);
  endtask

  // mask, unmask, set-wins and acknowledge on the interrupt line
  task automatic t_irq;
    i_pesl_host.wr(8'h72, 8'h10);
    fire(8, 1'b1);
    @(posedge clk);
    fire(8, 1'b0);
    repeat (2) @(posedge clk);
    irqchk(1'b1);
    i_pesl_host.wr(8'h72, 8'h00);
    irqchk(1'b0);
    i_pesl_host.wr(8'h72, 8'h10);
    irqchk(1'b1);
    fire(8, 1'b1);
    fork
      i_pesl_host.wr(8'h67, 8'h10);
      begin
        @(posedge clk);
        fire(8, 1'b0);
      end
    join
    rdchk(8'h67, 8'h10);
    i_pesl_host.wr(8'h67, 8'h10);
    irqchk(1'b0);
    i_pesl_host.wr(8'h72, 8'h00);
  endtask

  task automatic t_shutdown;
    logic [3:0] seen;
    int         n;
    i_pesl_host.wr(8'h75, 8'h0f);
    repeat (3) @(posedge clk);
    chk("reg_en_q", 8'h0f, {4'h0, reg_en_q});
    ordered_thermal_shutdown_live <= 1'b1;
    seen = 4'hf;
    for (n = 0; n < 100 && seen !== 4'h0; n++)
    begin
      @(negedge clk);
      if (reg_en_q !== seen)
      begin
        chk("reg_en_q", {4'h0, seen >> 1}, {4'h0, reg_en_q});
        seen = reg_en_q;
      end
    end
    if (n == 100)
    begin
      fail_count++;
      end_of_test;
    end
    @(posedge clk);
    rdchk(8'h67, 8'h01);
    i_pesl_host.wr(8'h75, 8'h0f);
    repeat (4) @(posedge clk);
    chk("reg_en_q", 8'h00, {4'h0, reg_en_q});
    ordered_thermal_shutdown_live <= 1'b0;
    i_pesl_host.wr(8'h67, 8'h01);
    repeat (3) @(posedge clk);
    chk("reg_en_q", 8'h0f, {4'h0, reg_en_q});
    rdchk(8'h75, 8'hff);
  endtask

  // reset in mid-run wipes flags, masks, requests and the interrupt
  task automatic t_midreset;
    i_pesl_host.wr(8'h70, 8'h20);
    fire(0, 1'b1);
    @(posedge clk);
    fire(0, 1'b0);
    repeat (2) @(posedge clk);
    irqchk(1'b1);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk("reg_en_q", 8'h00, {4'h0, reg_en_q});
    rdchk(8'h65, 8'h00);
    rdchk(8'h70, 8'h00);
    rdchk(8'h75, 8'h00);
    irqchk(1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // pins idle low and the clock valid so reset leaves no stray flags
  initial
  begin
    evt = '0;
    evt.ext_clk_valid = 1'b1;
    thermal_warning_live = 1'b0;
    ordered_thermal_shutdown_live = 1'b0;
    reset_out_level = 1'b0;
    enable_pin = 1'b0;
    brk_rst = 1'b0;
    brk_irq = 1'b0;
    recovery_counter = 8'h00;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_reserved;
    t_events;
    t_irq;
    t_shutdown;
    t_midreset;
    end_of_test;
  end
endmodule
`default_nettype wire
